/* src/scpm_consts.svh */
// constants for the system clock and power-mode controller
// assumes inclusion by bare name from the controller and its package users
`ifndef SCPM_CONSTS_SVH
`define SCPM_CONSTS_SVH

// ----------------------------------------
// register offsets on the plain port
// ----------------------------------------
`define SCPM_OFS_CTL   4'h0
`define SCPM_OFS_HSC   4'h1
`define SCPM_OFS_STAT  4'h2

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define SCPM_SEL_HI    7
`define SCPM_SEL_LO    5
`define SCPM_HS_IDLE   1
`define SCPM_LS_IDLE   0
`define SCPM_HS_STB    1
`define SCPM_HS_EN     0
`define SCPM_ST_PDN    0
`define SCPM_ST_TO     1
`define SCPM_SEL_LS    3'h7
`define SCPM_SEL_HS    3'h0
`define SCPM_CTL_RST   8'h00
`define SCPM_HSEN_RST  1'h1
`define SCPM_ZERO8     8'h00

// ----------------------------------------
// timing: 100 MHz fabric clock
// ----------------------------------------
`define SCPM_CLK_NS       10
`define SCPM_HS_START_NS  1000
`define SCPM_HS_START_CYC ((`SCPM_HS_START_NS + `SCPM_CLK_NS - 1) / `SCPM_CLK_NS)

`endif

/* src/scpm_pkg.sv */
// types shared by the clock and power-mode controller
// assumes the constants header is available for include
package scpm_pkg;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {FAST, SLOW, SLEEP, IDLE0, IDLE1, IDLE2} scpm_mode_t;

  // ----------------------------------------
  // system clock control fields
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] sysclk_sel;
    logic       hs_idle_en;
    logic       ls_idle_en;
  } scpm_ctl_t;

  // ----------------------------------------
  // clock ticks handed to the rest of the chip
  // ----------------------------------------
  typedef struct packed {
    logic cpu;
    logic periph_hs;
    logic periph_ls;
    logic ls_raw;
  } scpm_clk_t;

endpackage

/* src/scpm_ctrl.sv */
// system clock selector, low-power mode sequencer and three registers
// assumes oscillator edges arrive as one-cycle ticks synchronous to clk_i
//
// How it works
// - select code 000 high_clk, 001..110 divide by 2..64, 111 low_clk
// - halt with both idle bits low enters sleep, low_clk to peripherals stops
// - in sleep the low-speed oscillator keeps running while watchdog is enabled
// - halt with only ls_idle_en high enters idle0, low_clk keeps peripherals
// - halt with both idle bits high enters idle1, both oscillators run
// - halt with only hs_idle_en high enters idle2, high-speed runs, low-speed only while watchdog is enabled
// - system clock control bits 4..2 read as zero
// - hs_idle_en decides whether high-speed oscillator runs while halted
// - ls_idle_en decides whether low-speed oscillator runs while halted
// - hs_osc_stable reads 0 while unstable, clears on enable, sets when stable
// - hs_osc_en enables high-speed oscillator, resets to one
// - high-speed control bits 7..2 read as zero
// - code 111 moves to slow mode only once low-speed oscillator is stable
// - restart from stopped high-speed oscillator is reported through hs_osc_stable
// - sleep stops cpu clock, all state is simply held
// - halt entry sets powerdown_flag and clears wdt_timeout_flag
// - halt entry clears watchdog counter, it runs on only if enabled
// - sources are nominal 8 MHz and 32 kHz internal oscillators
// - in slow mode high-speed oscillator follows its enable bit
//
// Added by the designer: strobed register access and the placing of the registers.
`include "scpm_consts.svh"
`timescale 1ns/10ps

module scpm_ctrl #(
  parameter int unsigned HS_START_CYC = `SCPM_HS_START_CYC,
  parameter int unsigned ADDR_W       = 4
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  input  wire logic              halt_i,
  input  wire logic              wake_i,
  input  wire logic              hs_tick_i,
  input  wire logic              ls_tick_i,
  input  wire logic              ls_osc_stable_i,
  input  wire logic              wdt_en_i,
  input  wire logic              wdt_timeout_i,
  input  wire logic              clr_pdn_i,
  output logic [7:0]             rdata_o,
  output scpm_pkg::scpm_clk_t    clk_o,
  output logic                   hs_osc_en_o,
  output logic                   ls_osc_en_o,
  output scpm_pkg::scpm_mode_t   mode_o,
  output logic                   powerdown_flag_o,
  output logic                   wdt_timeout_flag_o,
  output logic                   wdt_clear_o,
  output logic                   wdt_run_o
);

  localparam int unsigned CW = $clog2(HS_START_CYC + 1);
  localparam logic [CW-1:0] STB_LAST = CW'(HS_START_CYC - 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // a divided tick falls where the low code bits of the count are all ones
  function automatic logic div_hit(input logic [5:0] cnt, input logic [2:0] code);
    logic [5:0] mask;
    mask = 6'h3F >> (3'h6 - code);
    div_hit = (code == `SCPM_SEL_HS) ? 1'b1 : ((cnt & mask) == mask);
  endfunction

  function automatic scpm_pkg::scpm_mode_t halt_mode(input logic hs_idle, input logic ls_idle);
    case ({hs_idle, ls_idle})
      2'b00:   halt_mode = scpm_pkg::SLEEP;
      2'b01:   halt_mode = scpm_pkg::IDLE0;
      2'b11:   halt_mode = scpm_pkg::IDLE1;
      default: halt_mode = scpm_pkg::IDLE2;
    endcase
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  scpm_pkg::scpm_ctl_t  ctl_reg;
  scpm_pkg::scpm_mode_t mode_reg;
  scpm_pkg::scpm_mode_t mode_next;
  scpm_pkg::scpm_clk_t  clk_reg;
  scpm_pkg::scpm_clk_t  clk_next;
  logic           hs_en_reg;
  logic [2:0]     cur_sel_reg;
  logic [5:0]     div_cnt_reg;
  logic [CW-1:0]  stb_cnt_reg;
  logic           hs_stable_reg;
  logic           pdn_reg;
  logic           to_reg;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic           wclr_reg;
  logic           wrun_reg;
  logic           hs_on_reg;
  logic           ls_on_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // register strobes and halt bookkeeping
  wire wr_ctl_w   = we_i & (addr_i == ADDR_W'(`SCPM_OFS_CTL));
  wire wr_hsc_w   = we_i & (addr_i == ADDR_W'(`SCPM_OFS_HSC));
  wire halted_w   = (mode_reg == scpm_pkg::SLEEP) | (mode_reg == scpm_pkg::IDLE0) |
                    (mode_reg == scpm_pkg::IDLE1) | (mode_reg == scpm_pkg::IDLE2);
  wire halt_go_w  = halt_i & ~halted_w;
  wire wake_go_w  = halted_w & (wake_i | wdt_timeout_i);
  wire en_rise_w  = wr_hsc_w & wdata_i[`SCPM_HS_EN] & ~hs_en_reg;
  wire cur_ls_w   = (cur_sel_reg == `SCPM_SEL_LS);
  wire want_ls_w  = (ctl_reg.sysclk_sel == `SCPM_SEL_LS);

  // oscillator run decisions; active high-speed use forces it on
  wire hs_run_w = halted_w ? ctl_reg.hs_idle_en
                           : (hs_en_reg | ~cur_ls_w | ~want_ls_w);
  wire ls_run_w = halted_w ? (ctl_reg.ls_idle_en | wdt_en_i)
                           : 1'b1;

  // usable oscillator edges, nominal 8 MHz and 32 kHz sources
  wire hs_ok_w  = hs_run_w & hs_stable_reg & hs_tick_i;
  wire ls_ok_w  = ls_run_w & ls_osc_stable_i & ls_tick_i;
  wire hs_div_w = hs_ok_w & div_hit(div_cnt_reg, cur_sel_reg);
  wire src_tick_w = cur_ls_w ? ls_ok_w : hs_div_w;

  // a new source is taken only when it is ready and the old one just ticked,
  // so the cpu never sees a cut pulse; costs up to one slow period of latency
  wire new_rdy_w = want_ls_w ? ls_osc_stable_i
                             : (hs_stable_reg & hs_run_w);
  wire switch_w  = (ctl_reg.sysclk_sel != cur_sel_reg) & new_rdy_w & src_tick_w;

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      scpm_pkg::FAST,
      scpm_pkg::SLOW:
      begin
        if (halt_go_w)
          mode_next = halt_mode(ctl_reg.hs_idle_en, ctl_reg.ls_idle_en);
        else
          mode_next = cur_ls_w ? scpm_pkg::SLOW : scpm_pkg::FAST;
      end
      scpm_pkg::SLEEP,
      scpm_pkg::IDLE0,
      scpm_pkg::IDLE1,
      scpm_pkg::IDLE2:
      begin
        if (wake_go_w)
          mode_next = cur_ls_w ? scpm_pkg::SLOW : scpm_pkg::FAST;
      end
      default:
      begin
        mode_next = scpm_pkg::FAST;
      end
    endcase
  end

  // ----------------------------------------
  // clock ticks out
  // ----------------------------------------
  // cpu edges stop whenever halted; contents elsewhere simply hold
  always_comb
  begin
    clk_next.cpu       = src_tick_w & ~halted_w;
    clk_next.periph_hs = hs_ok_w;
    clk_next.periph_ls = ls_ok_w & (~halted_w | ctl_reg.ls_idle_en);
    clk_next.ls_raw    = ls_ok_w;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped addresses and unimplemented bits read as zero
  always_comb
  begin
    rdata_next = `SCPM_ZERO8;
    if (re_i)
    begin
      case (addr_i)
        ADDR_W'(`SCPM_OFS_CTL):
        begin
          rdata_next[`SCPM_SEL_HI:`SCPM_SEL_LO] = ctl_reg.sysclk_sel;
          rdata_next[`SCPM_HS_IDLE] = ctl_reg.hs_idle_en;
          rdata_next[`SCPM_LS_IDLE] = ctl_reg.ls_idle_en;
        end
        ADDR_W'(`SCPM_OFS_HSC):
        begin
          rdata_next[`SCPM_HS_STB] = hs_stable_reg;
          rdata_next[`SCPM_HS_EN]  = hs_en_reg;
        end
        ADDR_W'(`SCPM_OFS_STAT):
        begin
          rdata_next[`SCPM_ST_PDN] = pdn_reg;
          rdata_next[`SCPM_ST_TO]  = to_reg;
        end
        default:
        begin
          rdata_next = `SCPM_ZERO8;
        end
      endcase
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctl_reg   <= scpm_pkg::scpm_ctl_t'(5'h00);
      hs_en_reg <= `SCPM_HSEN_RST;
    end
    else
    begin
      if (wr_ctl_w)
        ctl_reg <= {wdata_i[`SCPM_SEL_HI:`SCPM_SEL_LO],
                    wdata_i[`SCPM_HS_IDLE], wdata_i[`SCPM_LS_IDLE]};
      if (wr_hsc_w)
        hs_en_reg <= wdata_i[`SCPM_HS_EN];
    end
  end

  // ----------------------------------------
  // high-speed stabilisation tracking
  // ----------------------------------------
  // count restarts on stop or on a fresh enable, flag reads 0 meanwhile
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stb_cnt_reg   <= '0;
      hs_stable_reg <= 1'b0;
    end
    else if (!hs_run_w || en_rise_w)
    begin
      stb_cnt_reg   <= '0;
      hs_stable_reg <= 1'b0;
    end
    else if (!hs_stable_reg)
    begin
      stb_cnt_reg   <= stb_cnt_reg + CW'(1);
      hs_stable_reg <= (stb_cnt_reg == STB_LAST);
    end
  end

  // ----------------------------------------
  // source selection and divider
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cur_sel_reg <= `SCPM_SEL_HS;
      div_cnt_reg <= 6'h00;
    end
    else if (switch_w)
    begin
      cur_sel_reg <= ctl_reg.sysclk_sel;
      div_cnt_reg <= 6'h00;
    end
    else if (hs_ok_w)
    begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // mode, status flags and watchdog hooks
  // ----------------------------------------
  // hardware set wins over a clear landing in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_reg <= scpm_pkg::FAST;
      pdn_reg  <= 1'b0;
      to_reg   <= 1'b0;
      wclr_reg <= 1'b0;
      wrun_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      pdn_reg  <= halt_go_w | (pdn_reg & ~clr_pdn_i);
      to_reg   <= wdt_timeout_i | (to_reg & ~halt_go_w);
      wclr_reg <= halt_go_w;
      wrun_reg <= wdt_en_i & ls_run_w;
    end
  end

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clk_reg   <= scpm_pkg::scpm_clk_t'(4'h0);
      rdata_reg <= `SCPM_ZERO8;
      hs_on_reg <= 1'b1;
      ls_on_reg <= 1'b1;
    end
    else
    begin
      clk_reg   <= clk_next;
      rdata_reg <= rdata_next;
      hs_on_reg <= hs_run_w;
      ls_on_reg <= ls_run_w;
    end
  end

  assign rdata_o            = rdata_reg;
  assign clk_o              = clk_reg;
  assign hs_osc_en_o        = hs_on_reg;
  assign ls_osc_en_o        = ls_on_reg;
  assign mode_o             = mode_reg;
  assign powerdown_flag_o   = pdn_reg;
  assign wdt_timeout_flag_o = to_reg;
  assign wdt_clear_o        = wclr_reg;
  assign wdt_run_o          = wrun_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_halt_in;
    halt_go_w;
  endsequence

  sequence s_to_ls;
    !cur_ls_w ##1 cur_ls_w;
  endsequence

  a_ctl_reserved: assert property (re_i && addr_i == ADDR_W'(`SCPM_OFS_CTL) |=> rdata_o[4:2] == 3'h0)
    else $error("reserved clock control bits read nonzero");
  a_hsc_reserved: assert property (re_i && addr_i == ADDR_W'(`SCPM_OFS_HSC) |=> rdata_o[7:2] == 6'h00)
    else $error("reserved oscillator control bits read nonzero");
  a_sleep_entry: assert property (s_halt_in ##0 !ctl_reg.hs_idle_en && !ctl_reg.ls_idle_en
    |=> mode_o == scpm_pkg::SLEEP ##1 !clk_o.periph_ls)
    else $error("sleep not entered");
  a_idle0_entry: assert property (s_halt_in ##0 !ctl_reg.hs_idle_en && ctl_reg.ls_idle_en
    |=> mode_o == scpm_pkg::IDLE0)
    else $error("idle0 not entered");
  a_idle1_entry: assert property (s_halt_in ##0 ctl_reg.hs_idle_en && ctl_reg.ls_idle_en
    |=> mode_o == scpm_pkg::IDLE1 ##1 hs_osc_en_o && ls_osc_en_o)
    else $error("idle1 not entered");
  a_idle2_entry: assert property (s_halt_in ##0 ctl_reg.hs_idle_en && !ctl_reg.ls_idle_en
    |=> mode_o == scpm_pkg::IDLE2)
    else $error("idle2 not entered");
  a_cpu_stopped: assert property (halted_w |=> !clk_o.cpu)
    else $error("cpu clock ran while halted");
  a_flags_halt: assert property (s_halt_in ##0 !wdt_timeout_i
    |=> powerdown_flag_o && !wdt_timeout_flag_o && wdt_clear_o ##1 !wdt_clear_o)
    else $error("halt entry flags wrong");
  a_sleep_ls_rc_osc: assert property (mode_o == scpm_pkg::SLEEP && wdt_en_i |=> ls_osc_en_o)
    else $error("low-speed stopped under watchdog");
  a_stable_clear: assert property (en_rise_w |=> !hs_stable_reg ##1 !hs_stable_reg)
    else $error("stable flag not restarted");
  a_ls_switch: assert property (s_to_ls |-> $past(ls_osc_stable_i))
    else $error("switched to unstable low-speed source");
  a_switch_edge: assert property ($changed(cur_sel_reg) |-> $past(src_tick_w))
    else $error("source change off a tick");
  a_div_two: assert property (cur_sel_reg == 3'h1 && hs_ok_w && !div_cnt_reg[0] |=> !clk_o.cpu)
    else $error("divide by two ticked early");

endmodule

/* tb/scpm_tb.sv */
// self-checking bench for the system clock and power-mode controller
// assumes the controller and its package are compiled first; oscillator ticks come from here
`timescale 1ns/10ps

module testbench;
  // ----------------------------------------
  // signals and counters
  // ----------------------------------------
  localparam int unsigned START_CYC = 20; // short startup count keeps the run brief
  logic                 clk_i           = 1'h0;
  logic                 arst_n_i        = 1'h0;
  logic [3:0]           addr_i          = 4'h0;
  logic [7:0]           wdata_i         = 8'h00;
  logic                 we_i            = 1'h0;
  logic                 re_i            = 1'h0;
  logic                 halt_i          = 1'h0;
  logic                 wake_i          = 1'h0;
  logic                 hs_tick_i       = 1'h0;
  logic                 ls_tick_i       = 1'h0;
  logic                 ls_osc_stable_i = 1'h1;
  logic                 wdt_en_i        = 1'h0;
  logic                 wdt_timeout_i   = 1'h0;
  logic                 clr_pdn_i       = 1'h0;
  logic [7:0]           rdata_o;
  scpm_pkg::scpm_clk_t  clk_o;
  logic                 hs_osc_en_o;
  logic                 ls_osc_en_o;
  scpm_pkg::scpm_mode_t mode_o;
  logic                 powerdown_flag_o;
  logic                 wdt_timeout_flag_o;
  logic                 wdt_clear_o;
  logic                 wdt_run_o;
  int                   n_mismatch  = 0;
  int                   check_count = 0;
  int                   seed        = 71;
  bit                   tick_on     = 1'b0;
  int                   c_cpu;
  int                   c_hs;
  int                   c_ls;
  int                   c_raw;
  int                   c_hin;
  int                   c_lin;

  scpm_ctrl #(.HS_START_CYC(START_CYC), .ADDR_W(4)) i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .halt_i(halt_i), .wake_i(wake_i), .hs_tick_i(hs_tick_i), .ls_tick_i(ls_tick_i),
    .ls_osc_stable_i(ls_osc_stable_i), .wdt_en_i(wdt_en_i), .wdt_timeout_i(wdt_timeout_i),
    .clr_pdn_i(clr_pdn_i), .rdata_o(rdata_o), .clk_o(clk_o), .hs_osc_en_o(hs_osc_en_o),
    .ls_osc_en_o(ls_osc_en_o), .mode_o(mode_o), .powerdown_flag_o(powerdown_flag_o),
    .wdt_timeout_flag_o(wdt_timeout_flag_o), .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o));

  // 100 MHz fabric clock
  always #5 clk_i = ~clk_i;

  // random oscillator edges, the low-speed one much sparser
  always @(posedge clk_i)
  begin
    hs_tick_i <= tick_on && (($random(seed) & 1) != 0);
    ls_tick_i <= tick_on && (($random(seed) & 7) == 0);
  end

  // ----------------------------------------
  // compare tasks and expectations
  // ----------------------------------------
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_mode(input string what, input scpm_pkg::scpm_mode_t exp, input scpm_pkg::scpm_mode_t got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // window edges cost a tick or two, so counts are compared with a tolerance
  task automatic chk_near(input string what, input int exp, input int got, input int tol);
    check_count++;
    if (got > exp + tol || got < exp - tol)
    begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic scpm_pkg::scpm_mode_t exp_mode(input logic hs_idle, input logic ls_idle);
    if (!hs_idle)
      return ls_idle ? scpm_pkg::IDLE0 : scpm_pkg::SLEEP;
    return ls_idle ? scpm_pkg::IDLE1 : scpm_pkg::IDLE2;
  endfunction

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    re_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'h0;
    #1;
    d = rdata_o;
  endtask

  task automatic pulse(input int which);
    @(posedge clk_i);
    case (which)
      0: halt_i <= 1'h1;
      1: wake_i <= 1'h1;
      2: wdt_timeout_i <= 1'h1;
      default: clr_pdn_i <= 1'h1;
    endcase
    @(posedge clk_i);
    {halt_i, wake_i, wdt_timeout_i, clr_pdn_i} <= 4'h0;
    #1;
  endtask

  task automatic count_ticks(input int n);
    {c_cpu, c_hs, c_ls, c_raw, c_hin, c_lin} = '0;
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      // int counters would swallow an unknown tick, so look at it first
      chk_flag("clk ticks known", 1'h0, $isunknown(clk_o));
      c_cpu += clk_o.cpu;
      c_hs += clk_o.periph_hs;
      c_ls += clk_o.periph_ls;
      c_raw += clk_o.ls_raw;
      c_hin += hs_tick_i;
      c_lin += ls_tick_i;
    end
  endtask

  task automatic wait_mode(input scpm_pkg::scpm_mode_t m, input int n);
    int i;
    i = 0;
    while (mode_o !== m && i < n)
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk_mode("mode reached", m, mode_o);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [7:0] r;
    logic       we;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'h1;
    tick_on = 1'b1;
    repeat (START_CYC + 4) @(posedge clk_i);
    bus_rd(4'h0, r);
    chk_reg("clock ctl reset", 8'h00, r);
    bus_rd(4'h1, r);
    chk_reg("hsc reset", 8'h03, r);
    // random traffic: unimplemented bits must read zero, stable bit read only
    for (int k = 0; k < 12; k++)
    begin
      d = $random(seed);
      bus_wr(4'h0, d);
      bus_rd(4'h0, r);
      chk_reg("clock ctl readback", d & 8'hE3, r);
      bus_wr(4'h1, d);
      bus_rd(4'h1, r);
      chk_reg("hsc readback", d & 8'h01, r & 8'hFD);
    end
    bus_wr(4'h1, 8'h01);
    bus_wr(4'h0, 8'h00);
    bus_wr(4'h5, 8'hFF);
    bus_rd(4'h5, r);
    chk_reg("unmapped read", 8'h00, r);
    bus_rd(4'h0, r);
    chk_reg("clock ctl after unmapped", 8'h00, r);
    wait_mode(scpm_pkg::FAST, 200);
    // every divide ratio of the fast clock
    for (int k = 0; k < 7; k++)
    begin
      bus_wr(4'h0, {k[2:0], 5'h00});
      // a ratio change waits for a tick of the old ratio, up to 64 source edges
      count_ticks(300);
      count_ticks(600);
      chk_near("cpu ticks", c_hin >> k, c_cpu, 2);
    end
    // slow mode waits for a stable low-speed oscillator
    @(posedge clk_i);
    ls_osc_stable_i <= 1'h0;
    bus_wr(4'h0, 8'hE0);
    repeat (50) @(posedge clk_i);
    #1;
    chk_mode("slow held off", scpm_pkg::FAST, mode_o);
    @(posedge clk_i);
    ls_osc_stable_i <= 1'h1;
    wait_mode(scpm_pkg::SLOW, 300);
    count_ticks(600);
    chk_near("slow cpu ticks", c_lin, c_cpu, 2);
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h1, r);
    chk_reg("hsc off", 8'h00, r);
    chk_flag("hs osc stopped", 1'h0, hs_osc_en_o);
    bus_wr(4'h1, 8'h01);
    bus_rd(4'h1, r);
    chk_reg("hsc restarting", 8'h01, r);
    repeat (START_CYC + 4) @(posedge clk_i);
    bus_rd(4'h1, r);
    chk_reg("hsc stable", 8'h03, r);
    chk_flag("hs osc running", 1'h1, hs_osc_en_o);
    bus_wr(4'h0, 8'h00);
    wait_mode(scpm_pkg::FAST, 300);
    pulse(2);
    chk_flag("timeout flag set", 1'h1, wdt_timeout_flag_o);
    // the four low-power modes, the last one left by a watchdog overflow
    for (int k = 0; k < 4; k++)
    begin
      we = (k == 0) || k[0];
      @(posedge clk_i);
      wdt_en_i <= we;
      bus_wr(4'h0, {6'h00, k[1:0]});
      pulse(0);
      chk_mode("halt mode", exp_mode(k[1], k[0]), mode_o);
      chk_flag("powerdown set", 1'h1, powerdown_flag_o);
      chk_flag("timeout cleared", 1'h0, wdt_timeout_flag_o);
      chk_flag("wdt clear pulse", 1'h1, wdt_clear_o);
      bus_rd(4'h2, r);
      chk_reg("status halted", 8'h01, r);
      count_ticks(80);
      chk_flag("wdt clear ended", 1'h0, wdt_clear_o);
      chk_flag("wdt run", we, wdt_run_o);
      chk_near("cpu stopped", 0, c_cpu, 0);
      chk_flag("hs osc halted", k[1], hs_osc_en_o);
      chk_flag("ls osc halted", k[0] | (k == 0), ls_osc_en_o);
      chk_flag("periph hs", k[1], c_hs > 0);
      chk_flag("periph ls", k[0], c_ls > 0);
      chk_flag("raw low-speed ticks", k != 2, c_raw > 0);
      pulse(k == 3 ? 2 : 1);
      chk_mode("woken", scpm_pkg::FAST, mode_o);
      bus_rd(4'h0, r);
      chk_reg("clock ctl kept", {6'h00, k[1:0]}, r);
    end
    chk_flag("timeout wake flag", 1'h1, wdt_timeout_flag_o);
    bus_rd(4'h2, r);
    chk_reg("status woken", 8'h03, r);
    pulse(3);
    chk_flag("powerdown cleared", 1'h0, powerdown_flag_o);
    bus_rd(4'h2, r);
    chk_reg("status cleared", 8'h02, r);
    tally_and_finish();
  end

  // hang guard, well beyond the roughly 8000 cycles the sequence needs
  initial
  begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    $display("BAD run length expected finish seen timeout");
    tally_and_finish();
  end
endmodule
